/* pkg/mbsc_pkg.sv */
// Constants and types for the motor brake and speed-curve block.
// Assumes a 9-bit speed command scale where 512 stands for full duty.
package mbsc_pkg;

    // =========================================================
    // Widths
    localparam int CMD_W = 9;
    localparam int PT_W = 10;
    localparam int SPEED_W = 16;
    localparam int SUM_W = 18;
    localparam int PROD_W = 24;
    localparam int SLOPE_W = 14;
    localparam int START_W = 12;

    // =========================================================
    // Curve scale points
    localparam logic [PT_W-1:0] CLAMP_BASE = 10'h101;
    localparam logic [PT_W-1:0] FULL_DUTY = 10'h200;
    localparam logic [PT_W-1:0] HALF_CMD = 10'h100;
    localparam logic [PT_W-1:0] ZERO_PT = 10'h000;
    localparam int CL_SLOPE_SHIFT = 6;
    localparam int OL_SLOPE_SHIFT = 10;
    localparam int OL_START_LSB = 4;
    localparam logic [SPEED_W-1:0] SPEED_SAT = 16'hFFFF;

    // =========================================================
    // Settle counter reset and done values
    localparam logic [1:0] SETTLE_RST = 2'h0;
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        MBSC_BRK_NONE,
        MBSC_BRK_SHORT,
        MBSC_BRK_REVERSE,
        MBSC_BRK_MILD
    } mbsc_brake_t;

    typedef struct packed {
        logic brake_polarity;
        logic [1:0] brake_kind_select;
        logic alarm_source_select;
        logic closed_loop;
        logic open_above_clamp;
        logic keep_running_low;
        logic full_at_zero_command;
        logic duty_sets_direction;
        logic [7:0] startup_threshold;
        logic [6:0] stop_threshold;
        logic [7:0] clamp_threshold;
        logic [3:0] clamp_hysteresis;
        logic [11:0] startup_speed;
        logic [13:0] curve_slope;
        logic [13:0] second_curve_slope;
        logic [7:0] change_point;
    } mbsc_cfg_t;

    typedef struct packed {
        logic charge_pump_low;
        logic overcurrent_shutdown;
        logic thermal_shutdown;
        logic motor_lock;
        logic low_speed;
    } mbsc_fault_t;

endpackage : mbsc_pkg

/* hdl/mbsc_sync2.sv */
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the destination runs on CLK with asynchronous active-low reset.
`timescale 1ns/1ps
module mbsc_sync2 import mbsc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);

    logic meta_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : mbsc_sync2

/* hdl/mbsc_curve.sv */
// Piecewise linear speed curve with an optional change point.
// Assumes thresholds are given on the 512 scale of the speed command.
`timescale 1ns/1ps
module mbsc_curve import mbsc_pkg::*; (
    input wire logic [PT_W-1:0] x,
    input wire logic [START_W-1:0] base,
    input wire logic [SLOPE_W-1:0] slope1,
    input wire logic [SLOPE_W-1:0] slope2,
    input wire logic [PT_W-1:0] start_pt,
    input wire logic [PT_W-1:0] chg_pt,
    input wire logic open_mode,
    output logic [SPEED_W-1:0] y
);

    // Rise of one segment: slope times run, scaled for the loop mode.
    function automatic logic [SUM_W-1:0] seg(input logic [SLOPE_W-1:0] s,
                                             input logic [PT_W-1:0] dx,
                                             input logic om);
        logic [PROD_W-1:0] p;
        p = PROD_W'(s) * PROD_W'(dx);
        seg = om ? SUM_W'(p >> OL_SLOPE_SHIFT) : SUM_W'(p >> CL_SLOPE_SHIFT);
    endfunction : seg

    logic [SUM_W-1:0] sum;
    logic use_chg;

    always_comb begin
        use_chg = (chg_pt != ZERO_PT) && (chg_pt > start_pt) && (x > chg_pt);
        if (x <= start_pt) begin
            sum = SUM_W'(base);
        end else if (use_chg) begin
            sum = SUM_W'(base) + seg(slope1, chg_pt - start_pt, open_mode)
                + seg(slope2, x - chg_pt, open_mode);
        end else begin
            sum = SUM_W'(base) + seg(slope1, x - start_pt, open_mode);
        end
        y = (sum > SUM_W'(SPEED_SAT)) ? SPEED_SAT : sum[SPEED_W-1:0];
    end

endmodule : mbsc_curve

/* hdl/mbsc_top.sv */
// Brake selection and speed-curve mapping for a fan motor pre-driver.
// Assumes the speed command arrives on CLK with a one-cycle valid strobe,
// the brake pin is asynchronous, and configuration is held steady.
`timescale 1ns/1ps
module mbsc_top import mbsc_pkg::*; (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic BRAKE_PIN,
    input wire mbsc_cfg_t CFG,
    input wire mbsc_fault_t FAULTS,
    input wire logic SPEED_VALID,
    input wire logic [CMD_W-1:0] SPEED_COMMAND,
    output logic [SPEED_W-1:0] TARGET_SPEED,
    output logic [PT_W-1:0] OUTPUT_DUTY,
    output logic OPEN_LOOP_ACTIVE,
    output logic DRIVE_ENABLE,
    output logic DIR_REVERSE,
    output mbsc_brake_t BRAKE_KIND,
    output logic ALERT_O,
    output logic ALERT_OE
);

    // True for every brake kind that takes the drive away.
    function automatic logic is_braking(input mbsc_brake_t k);
        is_braking = (k != MBSC_BRK_NONE);
    endfunction : is_braking

    // =========================================================
    // Brake pin synchronisation
    logic brake_pin_sync;
    logic brake_active;
    mbsc_brake_t brake_kind_next;

    mbsc_sync2 u_brake_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d(BRAKE_PIN),
        .q(brake_pin_sync)
    );

    // Polarity 1 inverts the pin so a low level requests braking.
    assign brake_active = brake_pin_sync ^ CFG.brake_polarity;

    always_comb begin
        if (brake_active) begin
            brake_kind_next = mbsc_brake_t'(CFG.brake_kind_select);
        end else begin
            brake_kind_next = MBSC_BRK_NONE;
        end
    end

    // =========================================================
    // Power-on braking window
    logic [1:0] settle_reg;
    logic settled;
    logic po_brake_reg;

    // The synchroniser output is not trusted until it has been filled.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            settle_reg <= SETTLE_RST;
        end else if (settle_reg != SETTLE_DONE) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    // Alert and window logic wait until the pin level has passed the synchroniser.
    assign settled = (settle_reg == SETTLE_DONE);

    // The window lasts from reset until the first settled cycle in which braking is not requested.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            po_brake_reg <= 1'b1;
        end else if (settled && !is_braking(brake_kind_next)) begin
            po_brake_reg <= 1'b0;
        end
    end

    // =========================================================
    // Alert selection
    logic alert_next;
    logic alert_base;

    always_comb begin
        alert_base = FAULTS.charge_pump_low | FAULTS.overcurrent_shutdown
            | FAULTS.thermal_shutdown;
        if (!settled) begin
            // Lock and low speed stay hidden until the brake pin level is known.
            alert_next = alert_base;
        end else if (po_brake_reg && is_braking(brake_kind_next)) begin
            alert_next = alert_base | (FAULTS.motor_lock && CFG.alarm_source_select
                && brake_kind_next == MBSC_BRK_REVERSE);
        end else if (CFG.alarm_source_select) begin
            alert_next = alert_base | FAULTS.low_speed;
        end else begin
            alert_next = alert_base | FAULTS.motor_lock;
        end
    end

    // Open-drain alert: the pin is pulled low while a fault is shown.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ALERT_OE <= 1'b0;
            ALERT_O <= 1'b0;
        end else begin
            ALERT_OE <= alert_next;
            ALERT_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            BRAKE_KIND <= MBSC_BRK_NONE;
        end else begin
            BRAKE_KIND <= brake_kind_next;
        end
    end

    // =========================================================
    // Threshold points on the 512 scale
    logic [PT_W-1:0] cmd;
    logic [PT_W-1:0] start_pt;
    logic [PT_W-1:0] stop_pt;
    logic [PT_W-1:0] clamp_pt;
    logic [PT_W-1:0] hys_pt;
    logic [PT_W-1:0] chg_pt;
    logic [PT_W:0] cmd_plus_hys;

    // Points are ten bits wide so that a clamp point of full duty still fits.
    assign cmd = PT_W'(SPEED_COMMAND);
    assign start_pt = PT_W'(CFG.startup_threshold);
    assign stop_pt = {2'h0, CFG.stop_threshold, 1'b0};
    assign clamp_pt = CLAMP_BASE + PT_W'(CFG.clamp_threshold);
    assign hys_pt = (PT_W'(CFG.clamp_hysteresis) + 10'h001) << 1;
    assign chg_pt = {1'b0, CFG.change_point, 1'b0};
    assign cmd_plus_hys = (PT_W + 1)'(cmd) + (PT_W + 1)'(hys_pt);

    // =========================================================
    // Run and above-clamp hysteresis
    logic run_reg;
    logic run_next;
    logic above_reg;
    logic above_next;

    // Between the stop and startup points the run flag keeps its last value.
    always_comb begin
        if (cmd > start_pt) begin
            run_next = 1'b1;
        end else if (cmd <= stop_pt) begin
            run_next = 1'b0;
        end else begin
            run_next = run_reg;
        end
    end

    // The release test adds the hysteresis to the command, so nothing can underflow.
    always_comb begin
        if (cmd > clamp_pt) begin
            above_next = 1'b1;
        end else if (cmd_plus_hys <= (PT_W + 1)'(clamp_pt)) begin
            above_next = 1'b0;
        end else begin
            above_next = above_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            run_reg <= 1'b0;
        end else if (SPEED_VALID) begin
            run_reg <= run_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            above_reg <= 1'b0;
        end else if (SPEED_VALID) begin
            above_reg <= above_next;
        end
    end

    // =========================================================
    // Curve evaluation
    logic open_mode;
    logic [START_W-1:0] base_val;
    logic [PT_W-1:0] curve_x;
    logic [SPEED_W-1:0] curve_y;
    logic [SPEED_W-1:0] max_y;

    assign open_mode = !CFG.closed_loop;

    // Open loop starts from the upper eight bits of the startup field.

    always_comb begin
        if (open_mode) begin
            base_val = START_W'(CFG.startup_speed[START_W-1:OL_START_LSB]);
        end else begin
            base_val = CFG.startup_speed;
        end
    end

    // Above the clamp point the curve stays at its clamp value.
    assign curve_x = (cmd > clamp_pt) ? clamp_pt : cmd;

    mbsc_curve u_curve (
        .x(curve_x),
        .base(base_val),
        .slope1(CFG.curve_slope),
        .slope2(CFG.second_curve_slope),
        .start_pt(start_pt),
        .chg_pt(chg_pt),
        .open_mode(open_mode),
        .y(curve_y)
    );

    // A second copy of the curve evaluated at the clamp point gives the maximum value.
    mbsc_curve u_curve_max (
        .x(clamp_pt),
        .base(base_val),
        .slope1(CFG.curve_slope),
        .slope2(CFG.second_curve_slope),
        .start_pt(start_pt),
        .chg_pt(chg_pt),
        .open_mode(open_mode),
        .y(max_y)
    );

    // =========================================================
    // Operating point selection
    logic [SPEED_W-1:0] val_next;
    logic force_open;
    logic [PT_W-1:0] force_duty;
    logic max_sel;

    // Picks either a curve value or a forced open-loop duty.
    always_comb begin
        val_next = '0;
        force_open = 1'b0;
        force_duty = ZERO_PT;
        max_sel = 1'b0;
        if (cmd == ZERO_PT) begin
            if (CFG.full_at_zero_command) begin
                max_sel = 1'b1;
            end else if (CFG.keep_running_low) begin
                val_next = SPEED_W'(base_val);
            end
        end else if (cmd <= start_pt) begin
            if (CFG.keep_running_low) begin
                if (CFG.full_at_zero_command && cmd <= stop_pt) begin
                    max_sel = 1'b1;
                end else begin
                    val_next = SPEED_W'(base_val);
                end
            end else if (cmd > stop_pt && run_next) begin
                val_next = SPEED_W'(base_val);
            end
        end else if (CFG.open_above_clamp && above_next) begin
            force_open = 1'b1;
            force_duty = cmd;
        end else begin
            val_next = curve_y;
        end
        // Maximum means full duty when the open-above-clamp option is set.
        if (max_sel) begin
            if (CFG.open_above_clamp) begin
                force_open = 1'b1;
                force_duty = FULL_DUTY;
            end else begin
                val_next = max_y;
            end
        end
    end

    // =========================================================
    // Output registers, refreshed on each command update
    logic [PT_W-1:0] duty_next;
    logic drive_next;

    always_comb begin
        if (force_open) begin
            duty_next = force_duty;
        end else if (open_mode) begin
            duty_next = (val_next > SPEED_W'(FULL_DUTY)) ? FULL_DUTY : val_next[PT_W-1:0];
        end else begin
            duty_next = ZERO_PT;
        end
        drive_next = (force_open || val_next != '0) && !is_braking(brake_kind_next);
    end

    // Target speed reads zero whenever the duty path drives the motor directly.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TARGET_SPEED <= '0;
            OUTPUT_DUTY <= ZERO_PT;
            OPEN_LOOP_ACTIVE <= 1'b0;
        end else if (SPEED_VALID) begin
            TARGET_SPEED <= (open_mode || force_open) ? '0 : val_next;
            OUTPUT_DUTY <= duty_next;
            OPEN_LOOP_ACTIVE <= open_mode || force_open;
        end
    end

    // Braking removes drive at once, without waiting for a command update.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DRIVE_ENABLE <= 1'b0;
        end else if (SPEED_VALID) begin
            DRIVE_ENABLE <= drive_next;
        end else if (is_braking(brake_kind_next)) begin
            DRIVE_ENABLE <= 1'b0;
        end
    end

    // Direction follows the command only while the option is set.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DIR_REVERSE <= 1'b0;
        end else if (SPEED_VALID) begin
            DIR_REVERSE <= CFG.duty_sets_direction && (cmd < HALF_CMD);
        end
    end

endmodule : mbsc_top

/* sim/mbsc_chk_sva.sv */
// Checker for the brake and speed-curve block, bound to mbsc_top.
// Assumes CFG is held steady around each speed update.
`timescale 1ns/1ps
module mbsc_chk import mbsc_pkg::*; (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic BRAKE_PIN,
    input wire mbsc_cfg_t CFG,
    input wire mbsc_fault_t FAULTS,
    input wire logic SPEED_VALID,
    input wire logic [CMD_W-1:0] SPEED_COMMAND,
    input wire logic [SPEED_W-1:0] TARGET_SPEED,
    input wire logic [PT_W-1:0] OUTPUT_DUTY,
    input wire logic OPEN_LOOP_ACTIVE,
    input wire logic DRIVE_ENABLE,
    input wire logic DIR_REVERSE,
    input wire mbsc_brake_t BRAKE_KIND,
    input wire logic ALERT_O,
    input wire logic ALERT_OE
);
    // ==========================================
    // Curve points on the 512 scale
    logic [PT_W-1:0] clamp_pt;
    logic [PT_W-1:0] stop_pt;
    assign clamp_pt = CLAMP_BASE + {2'h0, CFG.clamp_threshold};
    assign stop_pt = {2'h0, CFG.stop_threshold, 1'b0};
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    property p_brk_off;
        (BRAKE_PIN == CFG.brake_polarity) [*4] |-> BRAKE_KIND == MBSC_BRK_NONE;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("brake on with pin idle");
    property p_brk_kind;
        (BRAKE_PIN != CFG.brake_polarity) [*4] |-> BRAKE_KIND == CFG.brake_kind_select;
    endproperty
    a_brk_kind: assert property (p_brk_kind) else $error("wrong brake kind");
    property p_brk_stop;
        BRAKE_KIND != MBSC_BRK_NONE |-> !DRIVE_ENABLE;
    endproperty
    a_brk_stop: assert property (p_brk_stop) else $error("drive on while braking");
    property p_start;
        SPEED_VALID && SPEED_COMMAND > CFG.startup_threshold
            |=> DRIVE_ENABLE || BRAKE_KIND != MBSC_BRK_NONE;
    endproperty
    a_start: assert property (p_start) else $error("drive off above start");
    property p_stop;
        SPEED_VALID && SPEED_COMMAND != 9'h000 && {1'b0, SPEED_COMMAND} <= stop_pt
            && !CFG.keep_running_low |=> !DRIVE_ENABLE;
    endproperty
    a_stop: assert property (p_stop) else $error("drive on at stop");
    property p_dir;
        SPEED_VALID && CFG.duty_sets_direction
            |=> DIR_REVERSE == ($past(SPEED_COMMAND) < 9'h100);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_hold;
        !SPEED_VALID |=> $stable(TARGET_SPEED) && $stable(OUTPUT_DUTY) && $stable(DIR_REVERSE);
    endproperty
    a_hold: assert property (p_hold) else $error("curve output moved");
    property p_open;
        SPEED_VALID && !CFG.closed_loop |=> OPEN_LOOP_ACTIVE && TARGET_SPEED == 16'h0000;
    endproperty
    a_open: assert property (p_open) else $error("open loop flag wrong");
    property p_above;
        SPEED_VALID && CFG.closed_loop && CFG.open_above_clamp && {1'b0, SPEED_COMMAND} > clamp_pt
            |=> OPEN_LOOP_ACTIVE && OUTPUT_DUTY == {1'b0, $past(SPEED_COMMAND)};
    endproperty
    a_above: assert property (p_above) else $error("duty not following");
    property p_alert;
        FAULTS.charge_pump_low || FAULTS.overcurrent_shutdown || FAULTS.thermal_shutdown
            |=> ALERT_OE && !ALERT_O;
    endproperty
    a_alert: assert property (p_alert) else $error("fault not shown on alert");
endmodule : mbsc_chk
bind mbsc_top mbsc_chk u_chk (.CLK(CLK), .RST_B(RST_B), .BRAKE_PIN(BRAKE_PIN), .CFG(CFG),
    .FAULTS(FAULTS), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE),
    .SPEED_VALID(SPEED_VALID), .SPEED_COMMAND(SPEED_COMMAND), .TARGET_SPEED(TARGET_SPEED),
    .OUTPUT_DUTY(OUTPUT_DUTY), .OPEN_LOOP_ACTIVE(OPEN_LOOP_ACTIVE),
    .DRIVE_ENABLE(DRIVE_ENABLE), .DIR_REVERSE(DIR_REVERSE), .BRAKE_KIND(BRAKE_KIND));

/* sim/mbsc_host.sv */
// Fan host model driving the brake pin and the speed command.
// Assumes clk is the block's CLK; drives 1 ns after the rising edge.
`timescale 1ns/1ps
module mbsc_host import mbsc_pkg::*; (
    input wire logic clk,
    output logic brake_pin,
    output logic speed_valid,
    output logic [CMD_W-1:0] speed_command
);
    initial begin
        brake_pin = 1'b0;
        speed_valid = 1'b0;
        speed_command = '0;
    end
    // The command is inverted after its strobe so a stale value never matches.
    task automatic send(input logic [CMD_W-1:0] c);
        @(posedge clk);
        #1;
        speed_valid = 1'b1;
        speed_command = c;
        @(posedge clk);
        #1;
        speed_valid = 1'b0;
        speed_command = ~c;
    endtask : send
    task automatic set_brake(input logic b);
        @(posedge clk);
        #1;
        brake_pin = b;
    endtask : set_brake
endmodule : mbsc_host

/* sim/mbsc_top_tb_top.sv */
// Self-checking bench for the brake and speed-curve block.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
module mbsc_top_tb_top import mbsc_pkg::*; ;
    typedef struct packed {
        logic [8:0] cmd;
        logic [15:0] tgt;
        logic de;
    } mbsc_row_t;
    // Closed loop: start 100, stop 40, clamp 300, slope 2 per step, base 1000.
    localparam mbsc_row_t ROWS [8] = '{'{9'h096, 16'h044C, 1'b1}, '{9'h12C, 16'h0578, 1'b1},
        '{9'h190, 16'h0578, 1'b1}, '{9'h078, 16'h0410, 1'b1}, '{9'h03C, 16'h03E8, 1'b1},
        '{9'h028, 16'h0000, 1'b0}, '{9'h03C, 16'h0000, 1'b0}, '{9'h000, 16'h0000, 1'b0}};
    // Alert rows: brake kind, alarm select, faults, expected pull-down.
    localparam logic [8:0] ALR [7] = '{9'b01_0_00010_0, 9'b01_0_00100_1, 9'b10_0_00010_0,
        9'b10_1_00010_1, 9'b11_1_00010_0, 9'b11_0_10000_1, 9'b10_0_01000_1};
    logic clk;
    logic rst_b;
    logic brake_pin;
    logic speed_valid;
    logic [CMD_W-1:0] speed_command;
    mbsc_cfg_t cfg;
    mbsc_fault_t faults;
    logic [SPEED_W-1:0] target_speed;
    logic [PT_W-1:0] output_duty;
    logic open_loop_active;
    logic drive_enable;
    logic dir_reverse;
    mbsc_brake_t brake_kind;
    logic alert_oe;
    logic alert_o;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    mbsc_host u_host (.clk(clk), .brake_pin(brake_pin), .speed_valid(speed_valid),
        .speed_command(speed_command));
    mbsc_top u_dut (.CLK(clk), .RST_B(rst_b), .BRAKE_PIN(brake_pin), .CFG(cfg),
        .FAULTS(faults), .SPEED_VALID(speed_valid), .SPEED_COMMAND(speed_command),
        .TARGET_SPEED(target_speed), .OUTPUT_DUTY(output_duty),
        .OPEN_LOOP_ACTIVE(open_loop_active), .DRIVE_ENABLE(drive_enable),
        .DIR_REVERSE(dir_reverse), .BRAKE_KIND(brake_kind), .ALERT_O(alert_o),
        .ALERT_OE(alert_oe));
    // ==========================================
    // Helpers
    function automatic mbsc_cfg_t base_cfg();
        mbsc_cfg_t c;
        c = '0;
        c.closed_loop = 1'b1;
        c.startup_threshold = 8'h64;
        c.stop_threshold = 7'h14;
        c.clamp_threshold = 8'h2B;
        c.clamp_hysteresis = 4'h3;
        c.startup_speed = 12'h3E8;
        c.curve_slope = 14'h0080;
        c.second_curve_slope = 14'h0100;
        return c;
    endfunction : base_cfg
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    task automatic sc(input logic [8:0] c, input logic [15:0] t, input logic [9:0] d,
        input logic o, input logic e);
        u_host.send(c);
        chk(target_speed, t);
        chk(output_duty, d);
        chk(open_loop_active, o);
        chk(drive_enable, e);
    endtask : sc
    task automatic do_reset(input mbsc_cfg_t c, input logic pin);
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        cfg = c;
        u_host.set_brake(pin);
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic brake(input logic b);
        u_host.set_brake(b);
        repeat (4) @(posedge clk);
        #1;
    endtask : brake
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        mbsc_cfg_t c;
        rst_b = 1'b0;
        cfg = base_cfg();
        faults = '0;
        do_reset(base_cfg(), 1'b0);
        chk(target_speed, 0);
        chk(brake_kind, 0);
        chk(alert_oe, 0);
        foreach (ROWS[i]) begin
            sc(ROWS[i].cmd, ROWS[i].tgt, 10'h000, 1'b0, ROWS[i].de);
        end
        cfg.open_above_clamp = 1'b1;
        sc(9'h190, 16'h0000, 10'h190, 1'b1, 1'b1);
        sc(9'h127, 16'h0000, 10'h127, 1'b1, 1'b1);
        sc(9'h124, 16'h0568, 10'h000, 1'b0, 1'b1);
        cfg = base_cfg();
        cfg.change_point = 8'h64;
        sc(9'h0FA, 16'h0578, 10'h000, 1'b0, 1'b1);
        cfg = base_cfg();
        cfg.duty_sets_direction = 1'b1;
        u_host.send(9'h0FF);
        chk(dir_reverse, 1'b1);
        u_host.send(9'h100);
        chk(dir_reverse, 1'b0);
        cfg = base_cfg();
        cfg.keep_running_low = 1'b1;
        sc(9'h032, 16'h03E8, 10'h000, 1'b0, 1'b1);
        u_host.send(9'h000);
        chk(target_speed, 16'h03E8);
        cfg.keep_running_low = 1'b0;
        cfg.full_at_zero_command = 1'b1;
        u_host.send(9'h000);
        chk(target_speed, 16'h0578);
        cfg = base_cfg();
        cfg.closed_loop = 1'b0;
        cfg.curve_slope = 14'h0400;
        sc(9'h065, 16'h0000, 10'h03F, 1'b1, 1'b1);
        sc(9'h12C, 16'h0000, 10'h106, 1'b1, 1'b1);
        sc(9'h190, 16'h0000, 10'h106, 1'b1, 1'b1);
        cfg.open_above_clamp = 1'b1;
        sc(9'h190, 16'h0000, 10'h190, 1'b1, 1'b1);
        sc(9'h124, 16'h0000, 10'h0FE, 1'b1, 1'b1);
        cfg.full_at_zero_command = 1'b1;
        sc(9'h000, 16'h0000, 10'h200, 1'b1, 1'b1);
        cfg = base_cfg();
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                cfg.brake_polarity = p[0];
                cfg.brake_kind_select = k[1:0];
                brake(p[0]);
                u_host.send(9'h096);
                chk(drive_enable, 1'b1);
                brake(!p[0]);
                chk(brake_kind, k);
                chk(drive_enable, k == 0);
                brake(p[0]);
                chk(brake_kind, 0);
            end
        end
        foreach (ALR[i]) begin
            c = base_cfg();
            c.brake_kind_select = ALR[i][8:7];
            c.alarm_source_select = ALR[i][6];
            faults = ALR[i][5:1];
            do_reset(c, 1'b1);
            chk(alert_oe, ALR[i][0]);
            chk(alert_o, 1'b0);
        end
        faults = 5'b00010;
        brake(1'b0);
        chk(alert_oe, 1'b1);
        finish_test();
    end
endmodule : mbsc_top_tb_top
